//--- rtl/touch_adc_scan_control.sv
// Touch converter control register, scan sequencer and result registers
//
// Contract
// - Control register top bit reads pen contact; zero after reset.
// - Top bit written 0 means host-timed, 1 means self-timed touch conversions (codes 0001-0101).
// - Bit 14 reads 0 while converting, 1 when idle; 1 after reset.
// - Writing 1 to bit 14 aborts conversion and powers down immediately.
// - Code 0000 starts nothing; 0001 repeats X then Y until pen lifts.
// - Code 0010 repeats X, Y, Z1, Z2 until pen lifts or stop.
// - Code 0011 converts X only into the X result.
// - Code 0100 converts Y only into the Y result.
// - Code 0101 converts both pressure inputs into their two results.
// - Code 0110 converts first battery input into its result.
// - Code 0111 converts second battery input into its result.
// - Code 1000 converts auxiliary input into its result.
// - Codes 1010 and 1100 convert first and second temperature.
// - Code 1101 drives X+ X-; code 1111 drives Y+ X-; no conversion.
// - Width field: 00/11 twelve bits, 01 eight bits, 10 ten bits.
// - Results stored right-justified, upper four bits zero.
// - Result registers are read-only and clear on reset.
`timescale 1ns/1ps
`default_nettype none
`include "touch_adc_defs.svh"

module touch_adc_scan_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Decoded serial command word: page, address, strobes
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_page,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Pen contact from the panel comparator
  input wire logic pen_contact,
  // Analog converter
  output logic conv_start,
  output touch_adc_pkg::chan_e conv_channel,
  output logic converter_power_down,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  // Panel drivers {x_pos, x_neg, y_pos, y_neg}
  output logic [3:0] panel_drive
);
  import touch_adc_pkg::*;

  // ************************************************
  // Decode helpers
  // ************************************************

  function automatic logic [2:0] seq_len(input logic [3:0] c);
    case (c)
      `TA_SCAN_XY: seq_len = `TA_LEN_TWO;
      `TA_SCAN_XYZ: seq_len = `TA_LEN_FOUR;
      `TA_SCAN_Z: seq_len = `TA_LEN_TWO;
      `TA_SCAN_X, `TA_SCAN_Y, `TA_SCAN_BATTERY_FIRST_RESULT, `TA_SCAN_BATTERY_SECOND_RESULT,
      `TA_SCAN_AUX, `TA_SCAN_T1, `TA_SCAN_T2: seq_len = `TA_LEN_ONE;
      // Reserved codes, drivers-only codes and no-scan convert nothing
      default: seq_len = `TA_LEN_ZERO;
    endcase
  endfunction

  function automatic chan_e seq_chan(input logic [3:0] c, input logic [1:0] st);
    case (c)
      `TA_SCAN_XY: seq_chan = st[0] ? CH_Y : CH_X;
      `TA_SCAN_XYZ: begin
        case (st)
          2'h0: seq_chan = CH_X;
          2'h1: seq_chan = CH_Y;
          2'h2: seq_chan = CH_Z1;
          default: seq_chan = CH_Z2;
        endcase
      end
      `TA_SCAN_X: seq_chan = CH_X;
      `TA_SCAN_Y: seq_chan = CH_Y;
      `TA_SCAN_Z: seq_chan = st[0] ? CH_Z2 : CH_Z1;
      `TA_SCAN_BATTERY_FIRST_RESULT: seq_chan = CH_BATTERY_FIRST_RESULT;
      `TA_SCAN_BATTERY_SECOND_RESULT: seq_chan = CH_BATTERY_SECOND_RESULT;
      `TA_SCAN_AUX: seq_chan = CH_AUX;
      `TA_SCAN_T1: seq_chan = CH_T1;
      `TA_SCAN_T2: seq_chan = CH_T2;
      default: seq_chan = CH_X;
    endcase
  endfunction

  function automatic logic is_touch(input logic [3:0] c);
    is_touch = (c >= `TA_SCAN_XY) && (c <= `TA_SCAN_Z);
  endfunction

  function automatic logic is_cont(input logic [3:0] c);
    is_cont = (c == `TA_SCAN_XY) || (c == `TA_SCAN_XYZ);
  endfunction

  function automatic logic [3:0] drive_of(input logic [3:0] c);
    case (c)
      `TA_SCAN_DRV_X: drive_of = `TA_DRV_X;
      `TA_SCAN_DRV_Y: drive_of = `TA_DRV_Y;
      `TA_SCAN_DRV_YX: drive_of = `TA_DRV_YX;
      default: drive_of = `TA_DRV_OFF;
    endcase
  endfunction

  // ************************************************
  // State
  // ************************************************

  ctl_s s;
  ctl_s n;
  logic pen;
  logic idle;
  logic wr_hit;
  logic rd_ctrl;
  logic abort;
  logic host_go;
  logic self_go;
  logic eng_done;
  logic [11:0] eng_result;

  assign pen = s.pen_sync[1];
  assign idle = (s.st == ST_IDLE);
  assign wr_hit = reg_wr && reg_page == `TA_PAGE_CTRL && reg_addr == `TA_ADDR_CTRL;
  assign rd_ctrl = reg_rd && reg_page == `TA_PAGE_CTRL && reg_addr == `TA_ADDR_CTRL;
  assign abort = wr_hit && reg_wdata[`TA_BIT_STOP];
  // Host timing starts on the write; battery, aux and temperature are always host-started
  assign host_go = wr_hit && !reg_wdata[`TA_BIT_STOP]
    && (!reg_wdata[`TA_BIT_MODE] || !is_touch(reg_wdata[`TA_SCAN_HI:`TA_SCAN_LO]))
    && seq_len(reg_wdata[`TA_SCAN_HI:`TA_SCAN_LO]) != `TA_LEN_ZERO;
  // Self timing waits for a fresh pen-down so single scans do not run back to back
  assign self_go = s.timing_self && !s.power_down && is_touch(s.scan)
    && pen && !s.pen_prev && !wr_hit;

  // ************************************************
  // Next state
  // ************************************************

  always_comb begin
    n = s;
    n.rvalid = 1'b0;
    n.pen_sync = {s.pen_sync[0], pen_contact};
    n.pen_prev = pen;
    if (reg_rd) begin
      n.rvalid = 1'b1;
      n.rdata = `TA_RD_NONE;
      if (rd_ctrl) begin
        n.rdata = {pen, idle, s.scan, s.width, s.low_byte};
      end else if (reg_page == `TA_PAGE_DATA) begin
        case (reg_addr)
          `TA_ADDR_X: n.rdata = s.res[CH_X];
          `TA_ADDR_Y: n.rdata = s.res[CH_Y];
          `TA_ADDR_Z1: n.rdata = s.res[CH_Z1];
          `TA_ADDR_Z2: n.rdata = s.res[CH_Z2];
          `TA_ADDR_BATTERY_FIRST_RESULT: n.rdata = s.res[CH_BATTERY_FIRST_RESULT];
          `TA_ADDR_BATTERY_SECOND_RESULT: n.rdata = s.res[CH_BATTERY_SECOND_RESULT];
          `TA_ADDR_AUX: n.rdata = s.res[CH_AUX];
          `TA_ADDR_T1: n.rdata = s.res[CH_T1];
          `TA_ADDR_T2: n.rdata = s.res[CH_T2];
          default: n.rdata = `TA_RD_NONE;
        endcase
      end
    end
    if (wr_hit) begin
      n.timing_self = reg_wdata[`TA_BIT_MODE];
      n.power_down = reg_wdata[`TA_BIT_STOP];
      n.scan = reg_wdata[`TA_SCAN_HI:`TA_SCAN_LO];
      n.width = reg_wdata[`TA_WID_HI:`TA_WID_LO];
      n.low_byte = reg_wdata[`TA_LOW_HI:0];
    end
    case (s.st)
      ST_IDLE: begin
        if (host_go || self_go) begin
          n.step = 2'h0;
          n.chan = seq_chan(n.scan, 2'h0);
          n.st = ST_CONV;
        end
      end
      ST_CONV: begin
        if (eng_done) begin
          n.res[s.chan] = {`TA_RES_PAD, eng_result};
          n.st = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if ({1'b0, s.step} + 3'h1 < seq_len(s.scan)) begin
          n.step = s.step + 2'h1;
          n.chan = seq_chan(s.scan, n.step);
          n.st = ST_CONV;
        end else if (is_cont(s.scan) && pen) begin
          n.step = 2'h0;
          n.chan = seq_chan(s.scan, 2'h0);
          n.st = ST_CONV;
        end else begin
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (abort) begin
      n.st = ST_IDLE;
      n.step = 2'h0;
    end
    n.drive = n.power_down ? `TA_DRV_OFF : drive_of(n.scan);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.res <= '0;
    end else begin
      s <= n;
    end
  end

  // ************************************************
  // Conversion engine
  // ************************************************

  touch_conv_engine u_engine (
    .sys_clk(sys_clk),
    .srst(srst),
    .start((s.st != ST_CONV) && (n.st == ST_CONV)),
    .abort(abort),
    .width(s.width),
    .done(eng_done),
    .result(eng_result),
    .conv_start(conv_start),
    .conv_done(conv_done),
    .conv_data(conv_data)
  );

  assign reg_rdata = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign conv_channel = s.chan;
  assign converter_power_down = s.power_down;
  assign panel_drive = s.drive;

  // ************************************************
  // Checks
  // ************************************************

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence seq_xy_first;
    s.st == ST_NEXT && s.scan == `TA_SCAN_XY && s.step == 2'h0 && !abort;
  endsequence

  sequence seq_set_end;
    s.st == ST_NEXT && is_cont(s.scan) && {1'b0, s.step} + 3'h1 >= seq_len(s.scan);
  endsequence

  AST_PEN_READ: assert property (rd_ctrl |=> reg_rdata[`TA_BIT_MODE] == $past(pen))
    else $error("pen bit does not follow contact");

  AST_IDLE_READ: assert property (rd_ctrl |=> reg_rdata[`TA_BIT_STOP] == $past(idle))
    else $error("idle bit does not follow sequencer");

  AST_ABORT: assert property (abort |=> idle && converter_power_down && !conv_start)
    else $error("stop did not abort and power down");

  // Start pulse leaves the engine on the same edge that enters the conversion state
  AST_SELF_START: assert property (idle && self_go && !abort |=> s.st == ST_CONV && conv_start)
    else $error("self-timed scan did not start");

  AST_NO_SCAN: assert property (idle && wr_hit && !self_go
    && seq_len(reg_wdata[`TA_SCAN_HI:`TA_SCAN_LO]) == `TA_LEN_ZERO |=> idle)
    else $error("non-converting code started a scan");

  AST_XY_ORDER: assert property (seq_xy_first |=> s.st == ST_CONV && conv_channel == CH_Y)
    else $error("Y did not follow X");

  AST_PEN_LOSS: assert property (seq_set_end and (!pen && !abort) |=> idle)
    else $error("scan continued after pen lift");

  AST_REPEAT: assert property (seq_set_end and (pen && !abort) |=>
    s.st == ST_CONV && conv_channel == CH_X)
    else $error("continuous scan did not repeat");

  AST_STORE: assert property (s.st == ST_CONV && eng_done && !abort |=>
    s.res[$past(s.chan)] == {4'h0, $past(eng_result)})
    else $error("result not stored right-justified");

  AST_RES_ONLY_SEQ: assert property (!$stable(s.res) |-> $past(s.st == ST_CONV && eng_done))
    else $error("result changed outside a conversion");

  AST_DRIVE_X: assert property (wr_hit && !reg_wdata[`TA_BIT_STOP]
    && reg_wdata[`TA_SCAN_HI:`TA_SCAN_LO] == `TA_SCAN_DRV_X
    |=> panel_drive == `TA_DRV_X && idle)
    else $error("X drivers not switched on");

  AST_DRIVE_Y: assert property (wr_hit && !reg_wdata[`TA_BIT_STOP]
    && reg_wdata[`TA_SCAN_HI:`TA_SCAN_LO] == `TA_SCAN_DRV_Y |=> panel_drive == `TA_DRV_Y)
    else $error("Y drivers not switched on");

  AST_DRIVE_YX: assert property (wr_hit && !reg_wdata[`TA_BIT_STOP]
    && reg_wdata[`TA_SCAN_HI:`TA_SCAN_LO] == `TA_SCAN_DRV_YX |=> panel_drive == `TA_DRV_YX)
    else $error("mixed drivers not switched on");

  // Drivers must not load the panel while the converter is off
  AST_PD_DRIVE: assert property (converter_power_down |-> panel_drive == `TA_DRV_OFF)
    else $error("panel driven while powered down");

endmodule // touch_adc_scan_control
`default_nettype wire

//--- include/touch_adc_defs.svh
// Register map, field positions, scan codes and reset values of the touch converter control
`ifndef TOUCH_ADC_DEFS_SVH
`define TOUCH_ADC_DEFS_SVH

`define TA_PAGE_DATA 4'h0
`define TA_PAGE_CTRL 4'h1
`define TA_ADDR_CTRL 6'h00
`define TA_ADDR_X 6'h00
`define TA_ADDR_Y 6'h01
`define TA_ADDR_Z1 6'h02
`define TA_ADDR_Z2 6'h03
`define TA_ADDR_BATTERY_FIRST_RESULT 6'h05
`define TA_ADDR_BATTERY_SECOND_RESULT 6'h06
`define TA_ADDR_AUX 6'h07
`define TA_ADDR_T1 6'h09
`define TA_ADDR_T2 6'h0a

`define TA_BIT_MODE 15
`define TA_BIT_STOP 14
`define TA_SCAN_HI 13
`define TA_SCAN_LO 10
`define TA_WID_HI 9
`define TA_WID_LO 8
`define TA_LOW_HI 7

`define TA_SCAN_NONE 4'h0
`define TA_SCAN_XY 4'h1
`define TA_SCAN_XYZ 4'h2
`define TA_SCAN_X 4'h3
`define TA_SCAN_Y 4'h4
`define TA_SCAN_Z 4'h5
`define TA_SCAN_BATTERY_FIRST_RESULT 4'h6
`define TA_SCAN_BATTERY_SECOND_RESULT 4'h7
`define TA_SCAN_AUX 4'h8
`define TA_SCAN_T1 4'ha
`define TA_SCAN_T2 4'hc
`define TA_SCAN_DRV_X 4'hd
`define TA_SCAN_DRV_Y 4'he
`define TA_SCAN_DRV_YX 4'hf

// Panel drivers as {x_pos, x_neg, y_pos, y_neg}
`define TA_DRV_OFF 4'h0
`define TA_DRV_X 4'hc
`define TA_DRV_Y 4'h3
`define TA_DRV_YX 4'h6

`define TA_WID_12 2'h0
`define TA_WID_8 2'h1
`define TA_WID_10 2'h2
`define TA_RES_PAD 4'h0
`define TA_RES_ZERO 16'h0000
`define TA_RD_NONE 16'h0000
`define TA_LEN_ZERO 3'h0
`define TA_LEN_ONE 3'h1
`define TA_LEN_TWO 3'h2
`define TA_LEN_FOUR 3'h4

`endif

//--- include/touch_adc_pkg.sv
// Types shared by the touch converter control and its conversion engine
package touch_adc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_NEXT = 3'b100
  } seq_state_e;

  typedef enum logic [3:0] {
    CH_X = 4'h0,
    CH_Y = 4'h1,
    CH_Z1 = 4'h2,
    CH_Z2 = 4'h3,
    CH_BATTERY_FIRST_RESULT = 4'h4,
    CH_BATTERY_SECOND_RESULT = 4'h5,
    CH_AUX = 4'h6,
    CH_T1 = 4'h7,
    CH_T2 = 4'h8
  } chan_e;

  typedef struct packed {
    seq_state_e st;
    logic timing_self;
    logic power_down;
    logic [3:0] scan;
    logic [1:0] width;
    logic [7:0] low_byte;
    logic [1:0] step;
    chan_e chan;
    logic [1:0] pen_sync;
    logic pen_prev;
    logic [15:0] rdata;
    logic rvalid;
    logic [3:0] drive;
    logic [8:0][15:0] res;
  } ctl_s;

  typedef struct packed {
    logic busy;
    logic req;
    logic done;
    logic [11:0] result;
  } eng_s;

endpackage

//--- rtl/touch_conv_engine.sv
// Single-conversion handshake with the analog converter and width justification
`timescale 1ns/1ps
`default_nettype none
`include "touch_adc_defs.svh"

module touch_conv_engine (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Sequencer side
  input wire logic start,
  input wire logic abort,
  input wire logic [1:0] width,
  output logic done,
  output logic [11:0] result,
  // Analog converter side
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [11:0] conv_data
);
  import touch_adc_pkg::*;

  eng_s s;
  eng_s n;

  // Analog result is MSB-aligned; shift down so narrow widths sit right-justified
  function automatic logic [11:0] justify(input logic [1:0] w, input logic [11:0] d);
    case (w)
      `TA_WID_8: justify = {4'h0, d[11:4]};
      `TA_WID_10: justify = {2'h0, d[11:2]};
      default: justify = d;
    endcase
  endfunction

  always_comb begin
    n = s;
    n.req = 1'b0;
    n.done = 1'b0;
    if (abort) begin
      // Drop the conversion at once, no result is produced
      n.busy = 1'b0;
    end else if (start) begin
      n.busy = 1'b1;
      n.req = 1'b1;
    end else if (s.busy && conv_done) begin
      n.busy = 1'b0;
      n.done = 1'b1;
      n.result = justify(width, conv_data);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done = s.done;
  assign result = s.result;
  assign conv_start = s.req;

  AST_WIDTH_8: assert property (@(posedge sys_clk) disable iff (srst)
    s.busy && conv_done && !abort && !start && width == `TA_WID_8 |=> result[11:8] == 4'h0)
    else $error("8-bit result not right-justified");

  AST_ABORT_NO_DONE: assert property (@(posedge sys_clk) disable iff (srst)
    abort |=> !done && !s.busy)
    else $error("aborted conversion still completed");

endmodule // touch_conv_engine
`default_nettype wire

//--- verification/conv_model.sv
// Behavioural analog converter answering start pulses after a set latency
`timescale 1ns/1ps
`default_nettype none

module conv_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Answer latency in cycles, at least 1
  input wire logic [7:0] lat,
  // Converter handshake
  input wire logic conv_start,
  input wire touch_adc_pkg::chan_e conv_channel,
  output logic conv_done,
  output logic [11:0] conv_data
);
  import touch_adc_pkg::*;
  logic [7:0] cnt_q;

  always_ff @(posedge sys_clk) begin
    conv_done <= 1'b0;
    // Data means nothing outside the done pulse, so it keeps moving
    conv_data <= ~conv_data;
    if (srst) begin
      cnt_q <= 8'h00;
      conv_data <= 12'h000;
    end else if (conv_start) begin
      cnt_q <= lat;
    end else if (cnt_q == 8'h01) begin
      cnt_q <= 8'h00;
      conv_done <= 1'b1;
      conv_data <= {conv_channel, 8'hc3};
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule // conv_model
`default_nettype wire

//--- verification/tb.sv
// Register-level testbench of the touch converter control
`timescale 1ns/1ps
`default_nettype none

module tb;
  import touch_adc_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_page = 4'h0;
  logic [5:0] reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic pen_contact = 1'b0;
  logic [7:0] lat = 8'h02;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic conv_start;
  chan_e conv_channel;
  logic converter_power_down;
  logic conv_done;
  logic [11:0] conv_data;
  logic [3:0] panel_drive;
  logic [15:0] rval;
  int error_cnt = 0;
  int checks_done = 0;
  int starts = 0;
  int s;
  int n;
  int i;
  int j;
  logic [3:0] sc [7] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc};
  logic [3:0] sh [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
  logic [5:0] sa [7] = '{6'h00, 6'h01, 6'h05, 6'h06, 6'h07, 6'h09, 6'h0a};
  logic [3:0] nc [6] = '{4'h0, 4'h9, 4'hb, 4'hd, 4'he, 4'hf};
  logic [3:0] nd [6] = '{4'h0, 4'h0, 4'h0, 4'hc, 4'h3, 4'h6};

  touch_adc_scan_control dut (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_page, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rvalid, .pen_contact, .conv_start, .conv_channel,
    .converter_power_down, .conv_done, .conv_data, .panel_drive);
  conv_model model (.sys_clk, .srst, .lat, .conv_start, .conv_channel, .conv_done,
    .conv_data);

  always #4 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (conv_start === 1'b1) starts++;
  end

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] pg, input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_page = pg;
    reg_addr = 6'h00;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] pg, input logic [5:0] a);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_page = pg;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk("read answer", 16'h0001, {15'h0000, reg_rvalid});
    rval = reg_rdata;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bounded poll of the idle flag
  task automatic wait_idle();
    for (n = 0; n < 100; n++) begin
      rd(4'h1, 6'h00);
      if (rval[14] === 1'b1) break;
    end
    if (n == 100) begin
      error_cnt++;
      $display("wrong value idle flag expected 1 seen 0");
      test_done();
    end
  endtask

  function automatic logic [15:0] expv(input logic [3:0] ch, input logic [1:0] w);
    logic [11:0] d;
    d = {ch, 8'hc3};
    case (w)
      2'h1: return {8'h00, d[11:4]};
      2'h2: return {6'h00, d[11:2]};
      default: return {4'h0, d};
    endcase
  endfunction

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    cyc(2);
    srst = 1'b0;
    cyc(2);
    rd(4'h1, 6'h00);
    chk("ctrl reset", 16'h4000, rval);
    rd(4'h0, 6'h00);
    chk("x reset", 16'h0000, rval);
    rd(4'h0, 6'h04);
    chk("unmapped", 16'h0000, rval);
    $display("reset test done");
    s = starts;
    foreach (nc[k]) begin
      wr(4'h1, {2'b00, nc[k], 2'b11, 8'ha5});
      cyc(6);
      rd(4'h1, 6'h00);
      chk("ctrl readback", {2'b01, nc[k], 2'b11, 8'ha5}, rval);
      chk("drivers", {12'h000, nd[k]}, {12'h000, panel_drive});
    end
    chk("quiet codes", 16'h0000, 16'(starts - s));
    $display("quiet code test done");
    // Width cycles through all four codes across the single conversions
    foreach (sc[k]) begin
      s = starts;
      wr(4'h1, {2'b00, sc[k], 2'(k), 8'h00});
      wait_idle();
      rd(4'h0, sa[k]);
      chk("single", expv(sh[k], 2'(k)), rval);
      chk("single count", 16'h0001, 16'(starts - s));
    end
    s = starts;
    wr(4'h1, 16'h1400);
    wait_idle();
    rd(4'h0, 6'h02);
    chk("z1", expv(4'h2, 2'h0), rval);
    rd(4'h0, 6'h03);
    chk("z2", expv(4'h3, 2'h0), rval);
    chk("z count", 16'h0002, 16'(starts - s));
    wr(4'h0, 16'hffff);
    rd(4'h0, 6'h00);
    chk("x read only", expv(4'h0, 2'h0), rval);
    $display("single conversion test done");
    for (j = 1; j < 3; j++) begin
      pen_contact = 1'b1;
      cyc(3);
      s = starts;
      wr(4'h1, {2'b00, 4'(j), 2'b10, 8'h00});
      cyc(60);
      rd(4'h1, 6'h00);
      chk("pen and busy", 16'h0002, {14'h0000, rval[15:14]});
      pen_contact = 1'b0;
      wait_idle();
      chk("repeats", 16'h0001, {15'h0000, starts - s > 2 * j});
      s = starts;
      cyc(20);
      chk("scan stopped", 16'h0000, 16'(starts - s));
      for (i = 0; i < 2 * j; i++) begin
        rd(4'h0, 6'(i));
        chk("scan result", expv(4'(i), 2'h2), rval);
      end
    end
    $display("scan test done");
    lat = 8'h28;
    s = starts;
    wr(4'h1, 16'h0d00);
    cyc(8);
    wr(4'h1, 16'h4000);
    cyc(1);
    chk("power down", 16'h0001, {15'h0000, converter_power_down});
    rd(4'h1, 6'h00);
    chk("abort idle", 16'h4000, rval);
    cyc(50);
    rd(4'h0, 6'h00);
    chk("abort keeps x", expv(4'h0, 2'h2), rval);
    chk("abort count", 16'h0001, 16'(starts - s));
    wr(4'h1, 16'h0000);
    cyc(1);
    chk("power up", 16'h0000, {15'h0000, converter_power_down});
    lat = 8'h02;
    $display("abort test done");
    s = starts;
    wr(4'h1, 16'h8c00);
    cyc(10);
    chk("self waits", 16'h0000, 16'(starts - s));
    pen_contact = 1'b1;
    cyc(20);
    wait_idle();
    chk("self start", 16'h0001, 16'(starts - s));
    chk("pen read", 16'h0001, {15'h0000, rval[15]});
    pen_contact = 1'b0;
    // Non-touch codes still start on the write in self-timed mode
    s = starts;
    wr(4'h1, 16'h9800);
    wait_idle();
    chk("self battery", 16'h0001, 16'(starts - s));
    rd(4'h0, 6'h05);
    chk("battery", expv(4'h4, 2'h0), rval);
    $display("self timing test done");
    @(negedge sys_clk);
    srst = 1'b1;
    cyc(2);
    srst = 1'b0;
    cyc(2);
    rd(4'h1, 6'h00);
    chk("ctrl after reset", 16'h4000, rval);
    rd(4'h0, 6'h00);
    chk("x after reset", 16'h0000, rval);
    rd(4'h0, 6'h05);
    chk("battery after reset", 16'h0000, rval);
    $display("mid-run reset test done");
    test_done();
  end
endmodule // tb
`default_nettype wire
